// [src/rbef_top.sv]
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Operation
// [R1] encoder sits on transmit and receive paths
// [R2] differential: one toggles level, zero holds
// [R3] inversion complements every bit
// [R4] manchester: two symbols per data bit
// [R5] self-synchronising whitening, no added bits
// [R6] one 256-byte fifo to the controller
// [R7] fifo chunks carry length and type header
// [R8] fifo direction follows transmit or receive
// [R9] controller polls status or count register
// [R10] empty, not empty, full, not full, level
// [R11] flags clear only by moving data; the level flag here also changes when the threshold register is written
// [R12] hdlc delimits packets, inserts and checks crc
// [R13] fixed-length and length-byte modes, optional crc
// [R14] diversity picks stronger antenna outside packets
// [R15] periodic rssi chunks into the fifo; here only with div_en also set and outside packets
// [R16] hdlc frames bounded by flag byte
// [R17] crc result appended after received data
// [R18] raw mode only serialises and groups bytes
// [R19] level flag follows threshold side
// [R20] full writes and empty reads ignored
module rbef_top #(
  parameter int unsigned DIV_PERIOD = rbef_pkg::DIV_PERIOD_CYC
) (
  input  wire logic                    I_REF_CLK,
  input  wire logic                    I_RST_B,
  input  wire rbef_pkg::rbef_apb_req_s I_APB,
  output var  rbef_pkg::rbef_apb_rsp_s O_APB,
  input  wire logic                    I_RX_STB,
  input  wire logic                    I_RX_BIT,
  input  wire logic [7:0]              I_RSSI_A,
  input  wire logic [7:0]              I_RSSI_B,
  output logic                         O_TX_SYM,
  output logic                         O_ANT_SEL,
  output logic [4:0]                   O_FIFO_FLAGS
);
  import rbef_pkg::*;

  typedef struct packed {
    rbef_cfg_s      cfg;
    rbef_enc_s      enc;
    logic [8:0]     thr;
    logic           thr_side;
    logic [7:0]     fixlen;
    rbef_apb_rsp_s  rsp;
    logic [7:0]     wp;
    logic [7:0]     rp;
    logic [8:0]     cnt;
    logic [4:0]     flags;
    logic [15:0]    sym;
    logic           ph;
    logic [3:0]     tbits;
    logic [7:0]     tsr;
    logic           tsym;
    logic           tline;
    logic [16:0]    twsr;
    logic           txo;
    rbef_tx_e       ts;
    logic [4:0]     tlen;
    logic           teop;
    logic           tinp;
    logic [15:0]    tcrc;
    logic           tci;
    logic           rph;
    logic           rprev;
    logic [16:0]    rwsr;
    logic [7:0]     rsr;
    logic [2:0]     rcnt;
    logic           rinp;
    logic [1:0]     rn;
    logic [8:0]     rrem;
    logic [7:0]     h1;
    logic [7:0]     h0;
    logic [15:0]    rcrc;
    logic [3:0][7:0] pend;
    logic [2:0]     en;
    logic [2:0]     ei;
    logic [31:0]    dtim;
    logic           ant;
  } rbef_st_s;

  rbef_st_s   q;
  rbef_st_s   d;
  logic [7:0] mem [256];
  logic [7:0] rdat;
  logic       push;
  logic       hpop;
  logic       fpop;
  logic [7:0] wdat;
  logic       full;
  logic       empty;
  logic       tick;
  logic       w;
  logic       lv;
  logic       rv;
  logic       rd;
  logic       ro;
  logic [7:0] nsr;
  logic [8:0] rem_n;
  logic [15:0] crc_a;
  logic [8:0] c2;
  rbef_hdr_s  hdr;

  // crc-ccitt over one byte, msb first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign rdat  = mem[q.rp];
  assign full  = (q.cnt == FIFO_DEPTH);
  assign empty = (q.cnt == 9'h000);
  assign tick  = (q.sym == SYM_CYC - 16'h0001);
  assign hdr   = rbef_hdr_s'(rdat);
  assign c2    = q.cfg.crc_en ? CRC_BYTES : 9'h000;

  always_comb begin
    d     = q;
    push  = 1'b0;
    hpop  = 1'b0;
    fpop  = 1'b0;
    wdat  = 8'h00;
    w     = 1'b0;
    lv    = 1'b0;
    rv    = 1'b0;
    rd    = 1'b0;
    ro    = 1'b0;
    nsr   = q.rsr;
    rem_n = q.rrem;
    crc_a = q.rcrc;
    // ==========================================================
    // apb slave: one wait state, effects at the completing edge
    d.rsp.pready  = 1'b0;
    d.rsp.pslverr = 1'b0;
    if (I_APB.psel && I_APB.penable && !q.rsp.pready) begin
      d.rsp.pready = 1'b1;
      case (I_APB.paddr)
        A_CTRL:   d.rsp.prdata = {26'h0, q.cfg};
        A_ENC:    d.rsp.prdata = {28'h0, q.enc};
        A_DATA:   d.rsp.prdata = {24'h0, empty ? 8'h00 : rdat}; // R20
        A_STAT:   d.rsp.prdata = {25'h0, q.rinp, q.ant, q.flags}; // R9
        A_COUNT:  d.rsp.prdata = {23'h0, q.cnt}; // R9
        A_THR:    d.rsp.prdata = {15'h0, q.thr_side, 7'h0, q.thr};
        A_FIXLEN: d.rsp.prdata = {24'h0, q.fixlen};
        default: begin
          d.rsp.prdata  = 32'h0;
          d.rsp.pslverr = 1'b1;
        end
      endcase
    end else if (I_APB.psel && I_APB.penable && I_APB.pwrite) begin
      case (I_APB.paddr)
        A_CTRL: d.cfg = rbef_cfg_s'(I_APB.pwdata[CFG_W-1:0]);
        A_ENC:  d.enc = rbef_enc_s'(I_APB.pwdata[ENC_W-1:0]);
        A_DATA: begin
          if (q.cfg.tx_mode && !full) begin // R8 R20
            push = 1'b1;
            wdat = I_APB.pwdata[7:0];
          end
        end
        A_THR: begin
          d.thr      = I_APB.pwdata[8:0];
          d.thr_side = I_APB.pwdata[THR_SIDE_BIT];
        end
        A_FIXLEN: d.fixlen = I_APB.pwdata[7:0];
        default: ;
      endcase
    end else if (I_APB.psel && I_APB.penable && I_APB.paddr == A_DATA) begin
      hpop = !q.cfg.tx_mode && !empty; // R8 R20
    end
    // ==========================================================
    // transmit framer: pulls chunks, adds flags and crc
    if (q.tbits == 4'h0 && !q.ph) begin
      case (q.ts)
        TS_IDLE: begin
          if (q.cfg.tx_mode && !empty) begin // R7
            fpop   = 1'b1;
            d.tlen = hdr.len;
            d.teop = hdr.eop;
            d.ts   = TS_HDR;
          end
        end
        TS_HDR: begin
          if (!q.tinp) begin
            d.tcrc = CRC_INIT;
            if (q.cfg.fmode == FM_HDLC) begin // R12 R16
              d.tsr   = HDLC_FLAG;
              d.tbits = 4'h8;
            end
          end
          d.tinp = 1'b1;
          d.ts   = TS_DATA;
        end
        TS_DATA: begin
          if (q.tlen != 5'h00) begin
            if (q.cfg.tx_mode && !empty) begin // R18
              fpop    = 1'b1;
              d.tsr   = rdat;
              d.tbits = 4'h8;
              d.tcrc  = crc_upd(q.tcrc, rdat);
              d.tlen  = q.tlen - 5'h01;
            end
          end else if (!q.teop) begin
            d.ts = TS_IDLE;
          end else if (q.cfg.crc_en && q.cfg.fmode != FM_RAW) begin // R12 R13
            d.ts  = TS_CRC;
            d.tci = 1'b0;
          end else begin
            d.ts = TS_FLAG2;
          end
        end
        TS_CRC: begin
          d.tsr   = q.tci ? q.tcrc[15:8] : q.tcrc[7:0];
          d.tbits = 4'h8;
          d.tci   = 1'b1;
          if (q.tci) begin
            d.ts = TS_FLAG2;
          end
        end
        TS_FLAG2: begin
          if (q.cfg.fmode == FM_HDLC) begin // R16
            d.tsr   = HDLC_FLAG;
            d.tbits = 4'h8;
          end
          d.tinp = 1'b0;
          d.ts   = TS_IDLE;
        end
        default: d.ts = TS_IDLE;
      endcase
    end
    // ==========================================================
    // transmit encoder: whiten, differential, invert, manchester
    d.sym = tick ? 16'h0000 : q.sym + 16'h0001;
    if (tick && !q.ph && q.tbits != 4'h0) begin // R1
      w      = q.tsr[0] ^ (q.enc.whiten & (q.twsr[11] ^ q.twsr[16])); // R5
      d.twsr = {q.twsr[15:0], w};
      lv     = q.enc.diff ? (q.tline ^ w) : w; // R2
      d.tline = lv;
      d.tsym  = lv ^ q.enc.inv; // R3
      d.txo   = lv ^ q.enc.inv;
      d.tsr   = {1'b0, q.tsr[7:1]};
      d.tbits = q.tbits - 4'h1;
      d.ph    = 1'b1;
    end else if (tick && q.ph) begin
      d.txo = q.enc.manch ? ~q.tsym : q.tsym; // R4
      d.ph  = 1'b0;
    end
    // ==========================================================
    // chunk emitter toward the fifo in receive mode
    if (!q.cfg.tx_mode && q.ei != q.en && !full) begin // R8
      push = 1'b1;
      wdat = q.pend[q.ei];
      d.ei = q.ei + 3'h1;
    end
    // ==========================================================
    // antenna diversity and rssi chunks
    d.dtim = (q.dtim >= DIV_PERIOD - 1) ? 32'h0 : q.dtim + 32'h1;
    if (q.dtim >= DIV_PERIOD - 1 && q.cfg.div_en && !q.rinp) begin // R14
      d.ant = (I_RSSI_B > I_RSSI_A);
      if (q.cfg.rssi_en && !q.cfg.tx_mode && q.ei == q.en) begin // R15
        d.pend = {8'h00, I_RSSI_B, I_RSSI_A, HDR_RSSI};
        d.en   = 3'h3;
        d.ei   = 3'h0;
      end
    end
    // ==========================================================
    // receive decoder and framer; hdlc payload holding the flag
    // pattern ends the frame early since no bit stuffing is done
    if (I_RX_STB && !q.cfg.tx_mode) begin // R1
      d.rph = q.enc.manch ? ~q.rph : 1'b0; // R4
      if (!q.rph) begin
        rv      = I_RX_BIT ^ q.enc.inv; // R3
        rd      = q.enc.diff ? (rv ^ q.rprev) : rv; // R2
        d.rprev = rv;
        ro      = rd ^ (q.enc.whiten & (q.rwsr[11] ^ q.rwsr[16])); // R5
        d.rwsr  = {q.rwsr[15:0], rd};
        nsr     = {ro, q.rsr[7:1]};
        d.rsr   = nsr;
        crc_a   = (q.rn >= 2'h2) ? crc_upd(q.rcrc, q.h1) : q.rcrc;
        if (q.cfg.fmode != FM_RAW && nsr == HDLC_FLAG
            && (q.cfg.fmode == FM_HDLC || !q.rinp)) begin // R16
          if (q.cfg.fmode == FM_HDLC && q.rinp && q.rn == 2'h3 && q.cfg.crc_en) begin
            d.pend = {16'h0000, 7'h00, q.rcrc == {q.h0, q.h1}, HDR_RES}; // R12 R17
            d.en   = 3'h2;
            d.ei   = 3'h0;
          end
          d.rinp = 1'b1;
          d.rcnt = 3'h0;
          d.rn   = 2'h0;
          d.rcrc = CRC_INIT;
          d.rrem = {1'b0, q.fixlen} + c2; // R13
        end else if (q.rinp || q.cfg.fmode == FM_RAW) begin // R18
          d.rcnt = q.rcnt + 3'h1;
          if (q.rcnt == 3'h7) begin
            d.pend = {16'h0000, nsr, HDR_DATA}; // R7
            d.en   = 3'h2;
            d.ei   = 3'h0;
            d.rcrc = crc_a;
            d.h1   = q.h0;
            d.h0   = nsr;
            d.rn   = (q.rn == 2'h3) ? 2'h3 : q.rn + 2'h1;
            rem_n  = (q.cfg.fmode == FM_LEN && q.rn == 2'h0) ? {1'b0, nsr} + c2
                                                             : q.rrem - 9'h001;
            d.rrem = rem_n;
            if ((q.cfg.fmode == FM_FIXED || q.cfg.fmode == FM_LEN) && rem_n == 9'h000) begin // R13
              d.rinp = 1'b0;
              if (q.cfg.crc_en) begin // R17
                d.pend = {7'h00, crc_a == {nsr, q.h0}, HDR_RES, nsr, HDR_DATA};
                d.en   = 3'h4;
              end
            end
          end
        end
      end
    end
    // ==========================================================
    // fifo pointers and status flags
    if (push) begin
      d.wp = q.wp + 8'h01;
    end
    if (hpop || fpop) begin
      d.rp = q.rp + 8'h01;
    end
    d.cnt = q.cnt + {8'h00, push} - {8'h00, hpop | fpop}; // R6 R11
    d.flags[0] = (d.cnt == 9'h000); // R10
    d.flags[1] = (d.cnt != 9'h000);
    d.flags[2] = (d.cnt == FIFO_DEPTH);
    d.flags[3] = (d.cnt != FIFO_DEPTH);
    d.flags[4] = q.thr_side ? (d.cnt >= q.thr) : (d.cnt <= q.thr); // R19
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      q        <= '0;
      q.thr    <= THR_RST;
      q.fixlen <= FIXLEN_RST;
      q.flags  <= FLAGS_RST;
    end else begin
      q <= d;
    end
  end

  // storage has no reset; contents are only valid below the count
  always_ff @(posedge I_REF_CLK) begin
    if (push && I_RST_B) begin // R6
      mem[q.wp] <= wdat;
    end
  end

  assign O_APB        = q.rsp;
  assign O_TX_SYM     = q.txo;
  assign O_ANT_SEL    = q.ant;
  assign O_FIFO_FLAGS = q.flags;
endmodule
`default_nettype wire

// [src/rbef_pkg.sv]
`default_nettype none
// ==========================================================
// timing
package rbef_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  // line symbol rate; twice the data rate so that manchester fits
  localparam int          SYM_RATE_HZ    = 200_000;
  localparam logic [15:0] SYM_CYC        = 16'(CLK_HZ / SYM_RATE_HZ);
  localparam int          DIV_PERIOD_US  = 1000;
  localparam int unsigned DIV_PERIOD_CYC = DIV_PERIOD_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // register byte offsets and field positions
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_ENC          = 8'h04;
  localparam logic [7:0]  A_DATA         = 8'h08;
  localparam logic [7:0]  A_STAT         = 8'h0c;
  localparam logic [7:0]  A_COUNT        = 8'h10;
  localparam logic [7:0]  A_THR          = 8'h14;
  localparam logic [7:0]  A_FIXLEN       = 8'h18;
  localparam int          CFG_W          = 6;
  localparam int          ENC_W          = 4;
  localparam int          THR_SIDE_BIT   = 16;
  // ==========================================================
  // reset values and fixed codes
  localparam logic [8:0]  FIFO_DEPTH     = 9'h100;
  localparam logic [8:0]  THR_RST        = 9'h080;
  localparam logic [7:0]  FIXLEN_RST     = 8'h10;
  localparam logic [4:0]  FLAGS_RST      = 5'h19;
  localparam logic [7:0]  HDLC_FLAG      = 8'h7e;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [8:0]  CRC_BYTES      = 9'h002;
  localparam logic [7:0]  HDR_DATA       = 8'h01;
  localparam logic [7:0]  HDR_RES        = 8'h81;
  localparam logic [7:0]  HDR_RSSI       = 8'h22;
  // ==========================================================
  // types
  typedef enum logic [1:0] {FM_RAW, FM_HDLC, FM_FIXED, FM_LEN} rbef_fmode_e;
  typedef enum logic [1:0] {CT_DATA, CT_RSSI, CT_FOFS, CT_TIME} rbef_ctype_e;
  typedef enum logic [2:0] {
    TS_IDLE  = 3'b000,
    TS_HDR   = 3'b001,
    TS_DATA  = 3'b011,
    TS_CRC   = 3'b010,
    TS_FLAG2 = 3'b110
  } rbef_tx_e;
  typedef struct packed {
    logic        eop;
    rbef_ctype_e ctype;
    logic [4:0]  len;
  } rbef_hdr_s;
  typedef struct packed {
    logic        rssi_en;
    logic        div_en;
    logic        crc_en;
    rbef_fmode_e fmode;
    logic        tx_mode;
  } rbef_cfg_s;
  typedef struct packed {
    logic whiten;
    logic manch;
    logic diff;
    logic inv;
  } rbef_enc_s;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rbef_apb_req_s;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rbef_apb_rsp_s;
endpackage
`default_nettype wire

// [testbench/rbef_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rbef_host (
  input  wire logic                    i_clk,
  input  wire rbef_pkg::rbef_apb_rsp_s i_rsp,
  output var  rbef_pkg::rbef_apb_req_s o_req
);
  import rbef_pkg::*;
  initial o_req = '0;
  // ==========================================================
  // one access at a time, held until pready is seen at an edge;
  // pready is looked at on the falling edge, where it has settled, so the
  // rising edge that follows is the one at which the slave completes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge i_clk);
    o_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    do begin
      @(negedge i_clk);
    end while (i_rsp.pready !== 1'b1);
    r = i_rsp.prdata;
    e = i_rsp.pslverr;
    @(posedge i_clk);
    // released data flips so a stale word never passes for live data
    o_req <= '{1'b0, 1'b0, w, a, ~d};
  endtask
endmodule
`default_nettype wire

// [testbench/rbef_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module rbef_top_props #(
  parameter int unsigned DIV_PERIOD = 64
) (
  input wire logic                    I_REF_CLK,
  input wire logic                    I_RST_B,
  input wire rbef_pkg::rbef_apb_req_s I_APB,
  input wire rbef_pkg::rbef_apb_rsp_s O_APB,
  input wire logic                    I_RX_STB,
  input wire logic                    I_RX_BIT,
  input wire logic [7:0]              I_RSSI_A,
  input wire logic [7:0]              I_RSSI_B,
  input wire logic                    O_TX_SYM,
  input wire logic                    O_ANT_SEL,
  input wire logic [4:0]              O_FIFO_FLAGS
);
  import rbef_pkg::*;
  logic        sym_q;
  logic [15:0] run_q;
  // saturated in reset so a symbol grid not tied to reset cannot false-fire
  always_ff @(posedge I_REF_CLK) begin
    sym_q <= O_TX_SYM;
    if (!I_RST_B) begin
      run_q <= 16'hffff;
    end else if (O_TX_SYM != sym_q) begin
      run_q <= 16'h0000;
    end else if (run_q != 16'hffff) begin
      run_q <= run_q + 16'h0001;
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  // ==========================================================
  // fifo flags
  empty_pair_a: assert property (O_FIFO_FLAGS[0] == !O_FIFO_FLAGS[1])
    else $error("empty and not empty disagree");
  full_pair_a: assert property (O_FIFO_FLAGS[2] == !O_FIFO_FLAGS[3])
    else $error("full and not full disagree");
  empty_full_a: assert property (!(O_FIFO_FLAGS[0] && O_FIFO_FLAGS[2]))
    else $error("fifo empty and full at once");
  empty_read_a: assert property (O_APB.pready && !I_APB.pwrite && I_APB.paddr == A_DATA
    && O_FIFO_FLAGS[0] && $past(O_FIFO_FLAGS[0]) |-> O_APB.prdata == 32'h0)
    else $error("read of empty fifo returned data");
  // ==========================================================
  // register bus
  ready_next_a: assert property ($rose(I_APB.penable) && I_APB.psel |=> O_APB.pready)
    else $error("pready late");
  ready_pulse_a: assert property (O_APB.pready |=> !O_APB.pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (O_APB.pslverr |-> O_APB.pready)
    else $error("pslverr without pready");
  unmapped_a: assert property (O_APB.pready && I_APB.paddr > A_FIXLEN
    |-> O_APB.pslverr && O_APB.prdata == 32'h0)
    else $error("unmapped access not refused");
  // ==========================================================
  // line side
  sym_hold_a: assert property (O_TX_SYM != sym_q |-> run_q >= SYM_CYC - 16'h0001)
    else $error("line symbol shorter than a symbol period");
  ant_pick_a: assert property ($changed(O_ANT_SEL)
    |-> O_ANT_SEL == ($past(I_RSSI_B) > $past(I_RSSI_A)))
    else $error("antenna switched to weaker side");
endmodule
bind rbef_top rbef_top_props #(.DIV_PERIOD(DIV_PERIOD)) u_props (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_APB(I_APB), .O_APB(O_APB),
  .I_RX_STB(I_RX_STB), .I_RX_BIT(I_RX_BIT), .I_RSSI_A(I_RSSI_A),
  .I_RSSI_B(I_RSSI_B), .O_TX_SYM(O_TX_SYM), .O_ANT_SEL(O_ANT_SEL),
  .O_FIFO_FLAGS(O_FIFO_FLAGS));
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rbef_pkg::*;
  logic          clk          = 1'b0;
  logic          rst_b        = 1'b0;
  logic          stb          = 1'b0;
  logic          rxb          = 1'b0;
  logic [7:0]    ra           = 8'h00;
  logic [7:0]    rb           = 8'h00;
  logic          sym;
  logic          ant;
  logic [4:0]    flags;
  rbef_apb_req_s req;
  rbef_apb_rsp_s rsp;
  int            fails        = 0;
  int            total_checks = 0;
  integer        seed         = 11;
  int            q[$];
  int            n;
  logic [31:0]   rd;
  logic          err;
  logic [16:0]   sr           = '0;
  logic          lv           = 1'b0;
  logic [55:0]   got;
  logic [55:0]   s1;
  logic [7:0]    ad[6]        = '{A_CTRL, A_ENC, A_STAT, A_COUNT, A_THR, A_FIXLEN};
  logic [31:0]   rv[6]        = '{32'h0, 32'h0, 32'h19, 32'h0, 32'h80, 32'h10};
  always #10 clk = ~clk;
  rbef_top #(.DIV_PERIOD(64)) u_rbef_top (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_APB(req), .O_APB(rsp), .I_RX_STB(stb),
    .I_RX_BIT(rxb), .I_RSSI_A(ra), .I_RSSI_B(rb), .O_TX_SYM(sym), .O_ANT_SEL(ant),
    .O_FIFO_FLAGS(flags));
  rbef_host u_rbef_host (.i_clk(clk), .i_rsp(rsp), .o_req(req));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_rbef_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_rbef_host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, e);
  endtask
  task automatic drain();
    while (q.size() > 0) begin
      rdc(A_DATA, 32'(q.pop_front()));
    end
  endtask
  // inverted, differential and whitened symbols, as the far transmitter sends
  task automatic rx_byte(input logic [7:0] b);
    logic w;
    for (int i = 0; i < 8; i++) begin
      w = b[i] ^ sr[11] ^ sr[16];
      sr = {sr[15:0], w};
      lv = lv ^ w;
      @(posedge clk);
      stb <= 1'b1;
      rxb <= ~lv;
      @(posedge clk);
      stb <= 1'b0;
      repeat (2) @(posedge clk);
    end
    q.push_back(32'h01);
    q.push_back(32'(b));
  endtask
  function automatic logic [15:0] crc16(input logic [23:0] p);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 3; i++) begin
      c = c ^ {p[8*i +: 8], 8'h00};
      for (int j = 0; j < 8; j++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(flags, FLAGS_RST);
    for (int i = 0; i < 6; i++) begin
      rdc(ad[i], rv[i]);
    end
    rdc(8'h1c, 32'h0);
    chk(err, 1'b1);
    n = $random(seed);
    ra <= n[7:0];
    rb <= n[7:0] ^ 8'h5a;
    wr(A_CTRL, 32'h30);
    repeat (70) @(posedge clk);
    wr(A_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk(ant, rb > ra);
    u_rbef_host.xfer(1'b0, A_COUNT, 32'h0, rd, err);
    n = int'(rd);
    chk(n == 3 || n == 6, 1'b1);
    repeat (n / 3) begin
      q.push_back(32'h22);
      q.push_back(32'(ra));
      q.push_back(32'(rb));
    end
    drain();
    wr(A_ENC, 32'hb);
    repeat (128) rx_byte(8'($random(seed)));
    repeat (4) @(posedge clk);
    chk(flags, 5'h06);
    wr(A_DATA, 32'h55);
    wr(A_THR, 32'h0001_00c8);
    repeat (2) @(posedge clk);
    chk(flags, 5'h16);
    rdc(A_COUNT, 32'h100);
    drain();
    repeat (2) @(posedge clk);
    chk(flags, 5'h09);
    rdc(A_DATA, 32'h0);
    // hdlc frame with crc, manchester line
    n = $random(seed);
    wr(A_ENC, 32'h4);
    wr(A_CTRL, 32'hb);
    wr(A_DATA, 32'h83);
    for (int i = 0; i < 3; i++) begin
      wr(A_DATA, 32'(n[8*i +: 8]));
    end
    while (sym !== 1'b1) @(posedge clk);
    for (int k = 0; k < 56; k++) begin
      repeat (125) @(posedge clk);
      got[k] = ~sym;
      repeat (250) @(posedge clk);
      s1[k] = sym;
      repeat (125) @(posedge clk);
    end
    chk(got, {HDLC_FLAG, crc16(n[23:0]), n[23:0], HDLC_FLAG});
    chk(s1[54:0], got[55:1]);
    end_of_test();
  end
endmodule
`default_nettype wire
